// file: src/ctu_cond_eval.sv
`timescale 1ns/100ps
module ctu_cond_eval
   import ctu_pkg::*;
(
   ctu_dec_if.eval dec
);
   // Flags are only read here, never written back
   assign dec.cond_true = ctu_cond_hit(dec.instr[COND_HI:COND_LO], dec.nzvc[3], dec.nzvc[2],
                                       dec.nzvc[1], dec.nzvc[0]);
endmodule : ctu_cond_eval

// file: src/ctu_dec_if.sv
`timescale 1ns/100ps
// Operands and flags handed to the evaluator and trap type former
interface ctu_dec_if;
   logic [31:0] instr;
   logic [31:0] src1_val;
   logic [31:0] src2_val;
   logic [3:0] nzvc;
   logic cond_true;
   logic [7:0] tt_value;
   logic rsvd_bad;
   modport top (output instr, output src1_val, output src2_val, output nzvc,
                input cond_true, input tt_value, input rsvd_bad);
   modport eval (input instr, input nzvc, output cond_true);
   modport form (input instr, input src1_val, input src2_val, output tt_value, output rsvd_bad);
endinterface : ctu_dec_if

// file: src/ctu_pkg.sv
package ctu_pkg;
   // Instruction word layout
   localparam int OP_HI = 31;
   localparam int OP_LO = 30;
   localparam int RSV_BIT = 29;
   localparam int COND_HI = 28;
   localparam int COND_LO = 25;
   localparam int OP3_HI = 24;
   localparam int OP3_LO = 19;
   localparam int I_BIT = 13;
   localparam int IMM_HI = 12;
   localparam int SWTRAP_HI = 6;
   localparam int RS2_UNUSED_LO = 5;
   localparam logic [1:0] OP_ARITH = 2'h2;
   localparam logic [5:0] OP3_TICC = 6'h3a;
   // Upper bits of the second operand that must be zero when i=0
   localparam int RS2_HIGH_LO = 7;
   // Trap type = 128 + low seven bits of the operand sum
   localparam logic [7:0] TT_BASE = 8'h80;
   localparam int TT_SUM_BITS = 7;
   // Trap base register layout
   localparam int TBA_LO = 12;
   localparam int TT_LO = 4;
   // Register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_MASK = 8'h08;
   localparam logic [7:0] REG_TBR = 8'h0c;
   localparam logic [7:0] REG_COUNT = 8'h10;
   localparam logic [7:0] REG_LAST = 8'h14;
   // Control and status fields
   localparam int CTRL_SVT = 0;
   localparam int ST_TAKEN = 0;
   localparam int ST_BLOCKED = 1;
   localparam int ST_RSVD = 2;
   localparam int ST_NOP = 3;
   localparam int ST_W = 4;
   localparam logic [ST_W-1:0] MASK_RST = 4'h0;
   localparam logic [31:0] TBR_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      CTU_IDLE = 2'b00,
      CTU_HOLD = 2'b01
   } ctu_state_type;

   // Condition field codes of the conditional trap family
   typedef enum logic [3:0] {
      C_NEVER = 4'b0000, C_ZERO = 4'b0001, C_LE = 4'b0010, C_LT = 4'b0011,
      C_LEU = 4'b0100, C_CS = 4'b0101, C_NEG = 4'b0110, C_VS = 4'b0111,
      C_ALW = 4'b1000, C_NZ = 4'b1001, C_GT = 4'b1010, C_GE = 4'b1011,
      C_GTU = 4'b1100, C_CC = 4'b1101, C_POS = 4'b1110, C_VC = 4'b1111
   } ctu_cond_type;

   // Evaluates a condition field against the integer flags
   function automatic logic ctu_cond_hit(input logic [3:0] cond, input logic n, input logic z,
                                          input logic v, input logic c);
      logic hit;
      hit = 1'b0;
      case (cond)
         C_NEVER: hit = 1'b0;
         C_ZERO: hit = z;
         C_LE: hit = z | (n ^ v);
         C_LT: hit = n ^ v;
         C_LEU: hit = c | z;
         C_CS: hit = c;
         C_NEG: hit = n;
         C_VS: hit = v;
         C_ALW: hit = 1'b1;
         C_NZ: hit = ~z;
         C_GT: hit = ~(z | (n ^ v));
         C_GE: hit = ~(n ^ v);
         C_GTU: hit = ~(c | z);
         C_CC: hit = ~c;
         C_POS: hit = ~n;
         default: hit = ~v;
      endcase
      return hit;
   endfunction : ctu_cond_hit
endpackage : ctu_pkg

// file: src/ctu_top.sv
`timescale 1ns/100ps
// Functional notes
// - A taken trap loads trap type 128 plus low seven bits of operand sum.
// - Trap-if-carry-set traps when carry is 1 and nothing higher is pending.
// - Trap-if-carry-set with carry 0 behaves exactly as a no-operation.
// - Trap-on-zero traps when zero flag is 1, no-operation when 0.
// - Signed above traps when not (Z or (N xor V)).
// - Signed greater-or-equal traps when not (N xor V).
// - Unsigned above traps when not (C or Z).
// - Signed below traps when N xor V.
// - Signed less-or-equal traps when Z or (N xor V).
// - Unsigned less-or-equal traps when C or Z.
// - Trap-on-nonzero traps when zero flag is 0, unless higher trap pending.
// - Trap-never never traps; op 10, op3 111010, condition 0000.
// - A true condition traps only when no higher priority trap is pending.
// - With single-vector trapping the vector is the trap base, type ignored.
module ctu_top
   import ctu_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic instr_valid,
   output logic instr_ready,
   input wire logic [31:0] instr_word,
   input wire logic [31:0] first_source_reg,
   input wire logic [31:0] second_source_reg,
   input wire logic [3:0] icc_nzvc,
   input wire logic higher_trap_pending,
   output logic trap_req,
   input wire logic trap_ack,
   output logic [31:0] trap_vector,
   output logic [31:0] trap_base_reg,
   output logic retire,
   output logic icc_write_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq
);
   generate
      if (ADDR_W < 8) begin : g_bad_addr
         $error("ctu_top: ADDR_W must be at least 8");
      end
   endgenerate

   ctu_dec_if dec ();

   ctu_cond_eval u_eval (
      .dec(dec.eval)
   );

   ctu_tt_form u_form (
      .dec(dec.form)
   );

   // Feed the helpers straight from the pipeline inputs
   assign dec.instr = instr_word;
   assign dec.src1_val = first_source_reg;
   assign dec.src2_val = second_source_reg;
   assign dec.nzvc = icc_nzvc;

   ctu_state_type state_q, state_d;
   logic [31:0] tbr_q, tbr_d;
   logic ctrl_svt_q, ctrl_svt_d;
   logic [ST_W-1:0] status_q, status_d;
   logic [ST_W-1:0] mask_q, mask_d;
   logic [31:0] count_q, count_d;
   logic [31:0] last_q, last_d;
   logic [31:0] rdata_q, rdata_d;
   logic trap_q, trap_d;
   logic retire_q, retire_d;
   logic [31:0] vector_q, vector_d;

   logic accept;
   logic is_ticc;
   logic hit;
   logic take;
   logic blocked;
   logic [ST_W-1:0] ev_set;
   logic [7:0] addr8;

   // Decode of the accepted instruction word
   always_comb begin
      accept = instr_valid && (state_q == CTU_IDLE);
      is_ticc = (instr_word[OP_HI:OP_LO] == OP_ARITH) && (instr_word[OP3_HI:OP3_LO] == OP3_TICC);
      // Trap-never falls out of the table as a constant zero
      hit = is_ticc && dec.cond_true;
      // A pending higher trap wins; this instruction then retires quietly
      take = accept && hit && !higher_trap_pending;
      blocked = accept && hit && higher_trap_pending;
      ev_set = '0;
      ev_set[ST_TAKEN] = take;
      ev_set[ST_BLOCKED] = blocked;
      ev_set[ST_RSVD] = accept && is_ticc && dec.rsvd_bad;
      ev_set[ST_NOP] = accept && !take;
      addr8 = reg_addr[7:0];
   end

   // Trap sequencing: hold the request until the sequencer acknowledges
   always_comb begin
      state_d = state_q;
      trap_d = trap_q;
      retire_d = 1'b0;
      vector_d = vector_q;
      tbr_d = tbr_q;
      last_d = last_q;
      count_d = count_q;
      case (state_q)
         CTU_IDLE: begin
            if (take) begin
               state_d = CTU_HOLD;
               trap_d = 1'b1;
               tbr_d[TBA_LO-1:TT_LO] = dec.tt_value;
               last_d = instr_word;
               count_d = count_q + 32'h0000_0001;
               // Single-vector mode ignores the type and lands on the base
               vector_d = ctrl_svt_q ? {tbr_q[31:TBA_LO], 12'h000}
                                     : {tbr_q[31:TBA_LO], dec.tt_value, 4'h0};
            end else if (accept) begin
               retire_d = 1'b1;
            end
         end
         CTU_HOLD: begin
            if (trap_ack) begin
               state_d = CTU_IDLE;
               trap_d = 1'b0;
               retire_d = 1'b1;
            end
         end
         default: begin
            state_d = CTU_IDLE;
            trap_d = 1'b0;
         end
      endcase
      // Software owns only the base address part of the trap base register
      if (reg_wr && (addr8 == REG_TBR)) begin
         tbr_d[31:TBA_LO] = reg_wdata[31:TBA_LO];
      end
   end

   // Register file: control, sticky status, mask, read port
   always_comb begin
      ctrl_svt_d = ctrl_svt_q;
      mask_d = mask_q;
      status_d = status_q;
      rdata_d = 32'h0000_0000;
      if (reg_wr) begin
         if (addr8 == REG_CTRL) begin
            ctrl_svt_d = reg_wdata[CTRL_SVT];
         end else if (addr8 == REG_MASK) begin
            mask_d = reg_wdata[ST_W-1:0];
         end
      end
      if (reg_rd) begin
         if (addr8 == REG_CTRL) begin
            rdata_d[CTRL_SVT] = ctrl_svt_q;
         end else if (addr8 == REG_STATUS) begin
            rdata_d[ST_W-1:0] = status_q;
            status_d = '0;
         end else if (addr8 == REG_MASK) begin
            rdata_d[ST_W-1:0] = mask_q;
         end else if (addr8 == REG_TBR) begin
            rdata_d = tbr_q;
         end else if (addr8 == REG_COUNT) begin
            rdata_d = count_q;
         end else if (addr8 == REG_LAST) begin
            rdata_d = last_q;
         end
      end
      // New events beat a clearing read in the same cycle
      status_d = status_d | ev_set;
   end

   // State registers
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_q <= CTU_IDLE;
         trap_q <= 1'b0;
         retire_q <= 1'b0;
         vector_q <= 32'h0000_0000;
         tbr_q <= TBR_RST;
         last_q <= 32'h0000_0000;
         count_q <= 32'h0000_0000;
         ctrl_svt_q <= 1'b0;
         mask_q <= MASK_RST;
         status_q <= '0;
         rdata_q <= 32'h0000_0000;
      end else begin
         state_q <= state_d;
         trap_q <= trap_d;
         retire_q <= retire_d;
         vector_q <= vector_d;
         tbr_q <= tbr_d;
         last_q <= last_d;
         count_q <= count_d;
         ctrl_svt_q <= ctrl_svt_d;
         mask_q <= mask_d;
         status_q <= status_d;
         rdata_q <= rdata_d;
      end
   end

   // Outputs
   assign instr_ready = (state_q == CTU_IDLE);
   assign trap_req = trap_q;
   assign trap_vector = vector_q;
   assign trap_base_reg = tbr_q;
   assign retire = retire_q;
   assign reg_rdata = rdata_q;
   assign irq = |(status_q & mask_q);
   // The unit never writes the flags, whatever the outcome
   assign icc_write_en = 1'b0;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // Checker's own reading of the condition table; the upper half negates the lower half
   logic chk_low;
   logic chk_hit;
   logic [7:0] chk_sum8;
   always_comb begin
      chk_low = 1'b0;
      case (instr_word[COND_HI-1:COND_LO])
         3'h1: chk_low = icc_nzvc[2];
         3'h2: chk_low = icc_nzvc[2] | (icc_nzvc[3] ^ icc_nzvc[1]);
         3'h3: chk_low = icc_nzvc[3] ^ icc_nzvc[1];
         3'h4: chk_low = icc_nzvc[0] | icc_nzvc[2];
         3'h5: chk_low = icc_nzvc[0];
         3'h6: chk_low = icc_nzvc[3];
         3'h7: chk_low = icc_nzvc[1];
         default: chk_low = 1'b0;
      endcase
      chk_hit = instr_word[COND_HI] ^ chk_low;
   end

   // Low seven sum bits need only the low operand bits; sign extension never reaches them
   assign chk_sum8 = {1'b0, first_source_reg[6:0]} + {1'b0, (instr_word[I_BIT] ? instr_word[6:0] : second_source_reg[6:0])};

   sequence s_take_carry;
      accept && is_ticc && (instr_word[COND_HI:COND_LO] == C_CS) && icc_nzvc[0] && !higher_trap_pending;
   endsequence

   property p_carry_trap;
      s_take_carry |=> trap_req && (state_q == CTU_HOLD);
   endproperty
   a_carry_trap: assert property (p_carry_trap) else $error("carry set did not trap");

   property p_carry_clear_nop;
      accept && is_ticc && (instr_word[COND_HI:COND_LO] == C_CS) && !icc_nzvc[0]
         |=> !trap_req && retire && $stable(trap_base_reg);
   endproperty
   a_carry_clear_nop: assert property (p_carry_clear_nop) else $error("carry clear was not a nop");

   property p_tt_value;
      take |=> trap_base_reg[TBA_LO-1:TT_LO] == (8'h80 + {1'b0, $past(chk_sum8[6:0])});
   endproperty
   a_tt_value: assert property (p_tt_value) else $error("trap type not loaded");

   property p_zero_trap;
      accept && is_ticc && (instr_word[COND_HI:COND_LO] == C_ZERO) && !higher_trap_pending
         |=> trap_req == $past(icc_nzvc[2]);
   endproperty
   a_zero_trap: assert property (p_zero_trap) else $error("zero flag trap wrong");

   property p_signed_conds;
      accept && is_ticc && !higher_trap_pending |=> trap_req == $past(chk_hit);
   endproperty
   a_signed_conds: assert property (p_signed_conds) else $error("condition outcome wrong");

   property p_never;
      accept && is_ticc && (instr_word[COND_HI:COND_LO] == C_NEVER) |=> !trap_req ##0 retire;
   endproperty
   a_never: assert property (p_never) else $error("trap never raised a trap");

   property p_priority;
      accept && higher_trap_pending |=> !trap_req && status_q[ST_NOP];
   endproperty
   a_priority: assert property (p_priority) else $error("trap raised over higher priority");

   property p_single_vector;
      take && ctrl_svt_q |=> trap_vector == {trap_base_reg[31:TBA_LO], 12'h000};
   endproperty
   a_single_vector: assert property (p_single_vector) else $error("single vector ignored");

   property p_hold_until_ack;
      trap_req && !trap_ack |=> trap_req && $stable(trap_vector);
   endproperty
   a_hold_until_ack: assert property (p_hold_until_ack) else $error("request dropped early");

   property p_flags_kept;
      instr_valid |-> !icc_write_en;
   endproperty
   a_flags_kept: assert property (p_flags_kept) else $error("flags written");

   property p_sticky;
      take |=> status_q[ST_TAKEN] [*2] or (status_q[ST_TAKEN] ##1 $past(reg_rd));
   endproperty
   a_sticky: assert property (p_sticky) else $error("taken status lost");

   property p_ge_trap;
      accept && is_ticc && !higher_trap_pending && (instr_word[COND_HI:COND_LO] == C_GE)
         |=> trap_req == $past(!(icc_nzvc[3] ^ icc_nzvc[1]));
   endproperty
   a_ge_trap: assert property (p_ge_trap) else $error("greater-or-equal trap wrong");

   property p_gtu_trap;
      accept && is_ticc && !higher_trap_pending && (instr_word[COND_HI:COND_LO] == C_GTU)
         |=> trap_req == $past(!(icc_nzvc[0] | icc_nzvc[2]));
   endproperty
   a_gtu_trap: assert property (p_gtu_trap) else $error("unsigned above trap wrong");

   property p_lt_trap;
      accept && is_ticc && !higher_trap_pending && (instr_word[COND_HI:COND_LO] == C_LT)
         |=> trap_req == $past(icc_nzvc[3] ^ icc_nzvc[1]);
   endproperty
   a_lt_trap: assert property (p_lt_trap) else $error("signed below trap wrong");

   property p_le_trap;
      accept && is_ticc && !higher_trap_pending && (instr_word[COND_HI:COND_LO] == C_LE)
         |=> trap_req == $past(icc_nzvc[2] | (icc_nzvc[3] ^ icc_nzvc[1]));
   endproperty
   a_le_trap: assert property (p_le_trap) else $error("signed less-or-equal trap wrong");

   property p_leu_trap;
      accept && is_ticc && !higher_trap_pending && (instr_word[COND_HI:COND_LO] == C_LEU)
         |=> trap_req == $past(icc_nzvc[0] | icc_nzvc[2]);
   endproperty
   a_leu_trap: assert property (p_leu_trap) else $error("unsigned less-or-equal trap wrong");

   property p_nz_trap;
      accept && is_ticc && !higher_trap_pending && (instr_word[COND_HI:COND_LO] == C_NZ)
         |=> trap_req == $past(!icc_nzvc[2]);
   endproperty
   a_nz_trap: assert property (p_nz_trap) else $error("nonzero trap wrong");

   property p_false_nop;
      accept && is_ticc && !chk_hit
         |=> !trap_req && retire && status_q[ST_NOP];
   endproperty
   a_false_nop: assert property (p_false_nop) else $error("false condition did not retire as nop");

   property p_typed_vector;
      take && !ctrl_svt_q
         |=> trap_vector == {trap_base_reg[31:TBA_LO], TT_BASE | {1'b0, $past(chk_sum8[6:0])}, 4'h0};
   endproperty
   a_typed_vector: assert property (p_typed_vector) else $error("typed vector wrong");
endmodule : ctu_top

// file: src/ctu_tt_form.sv
`timescale 1ns/100ps
module ctu_tt_form
   import ctu_pkg::*;
(
   ctu_dec_if.form dec
);
   logic [31:0] operand2;
   logic [31:0] sum;

   // Second operand is register or sign-extended immediate
   always_comb begin
      operand2 = dec.instr[I_BIT] ? {{19{dec.instr[IMM_HI]}}, dec.instr[IMM_HI:0]} : dec.src2_val;
      sum = dec.src1_val + operand2;
   end

   // Only seven sum bits matter, so the carry chain beyond bit 6 is dropped by synthesis
   assign dec.tt_value = TT_BASE | {1'b0, sum[TT_SUM_BITS-1:0]};

   // Flags words that break the zero-filling convention; software's duty, reported only
   assign dec.rsvd_bad = dec.instr[RSV_BIT] |
                         (dec.instr[I_BIT] ? (|dec.instr[IMM_HI:SWTRAP_HI+1])
                                           : ((|dec.instr[IMM_HI:RS2_UNUSED_LO]) |
                                              (|dec.src2_val[31:RS2_HIGH_LO])));
endmodule : ctu_tt_form

// file: testbench/ctu_seq_model.sv
`timescale 1ns/100ps
// Trap sequencer stand-in: acknowledges a held trap request after a chosen wait
module ctu_seq_model (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic trap_req,
   input wire logic [1:0] ack_delay,
   output logic trap_ack
);
   logic [1:0] wait_q;
   // Ack is a one-cycle pulse; dropping it at once keeps it from acking the next trap early
   always_ff @(posedge sys_clk) begin
      if (!resetn || trap_ack || !trap_req) begin
         trap_ack <= 1'b0;
         wait_q <= 2'h0;
      end else if (wait_q >= ack_delay) begin
         trap_ack <= 1'b1;
      end else begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule : ctu_seq_model

// file: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
   import ctu_pkg::*;
   logic sys_clk, resetn, instr_valid, instr_ready, higher_trap_pending, trap_req, trap_ack;
   logic retire, icc_write_en, reg_wr, reg_rd, irq, svt;
   logic [31:0] instr_word, first_source_reg, second_source_reg, trap_vector, trap_base_reg;
   logic [31:0] reg_wdata, reg_rdata, rd, lw;
   logic [3:0] icc_nzvc;
   logic [7:0] reg_addr;
   logic [1:0] ack_delay;
   logic [19:0] tba;
   int errors, total_checks, ntrap;

   ctu_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .instr_valid(instr_valid), .instr_ready(instr_ready),
      .instr_word(instr_word), .first_source_reg(first_source_reg), .second_source_reg(second_source_reg),
      .icc_nzvc(icc_nzvc), .higher_trap_pending(higher_trap_pending), .trap_req(trap_req),
      .trap_ack(trap_ack), .trap_vector(trap_vector), .trap_base_reg(trap_base_reg), .retire(retire),
      .icc_write_en(icc_write_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   ctu_seq_model seq_u (.sys_clk(sys_clk), .resetn(resetn), .trap_req(trap_req), .ack_delay(ack_delay),
      .trap_ack(trap_ack));

   task automatic check(input logic ok, input string what);
      total_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : check

   task automatic conclude();
      if (errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   // Bench's own view of the condition table: upper half is the negation of the lower half
   function automatic logic want(input logic [3:0] c, input logic [3:0] f);
      logic n, z, v, cy, h;
      {n, z, v, cy} = f;
      case (c[2:0])
         3'h0: h = 1'b0;
         3'h1: h = z;
         3'h2: h = z | (n ^ v);
         3'h3: h = n ^ v;
         3'h4: h = cy | z;
         3'h5: h = cy;
         3'h6: h = n;
         default: h = v;
      endcase
      return c[3] ? !h : h;
   endfunction : want

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read

   task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
      reg_read(a, rd);
      check(rd === exp, "register read value");
   endtask : reg_check

   // Operands stay legal except in the one deliberately illegal word: reserved bits zero, upper 25 bits of the register operand zero
   task automatic run_instr(input logic [3:0] c, input logic imm, input logic [31:0] a, input logic [31:0] b,
                            input logic [3:0] f, input logic pend, input logic exp);
      logic [31:0] sum;
      logic [7:0] tt;
      int n;
      sum = a + (imm ? {{19{b[12]}}, b[12:0]} : b);
      tt = 8'h80 | {1'h0, sum[6:0]};
      n = 0;
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      lw = {2'h2, 1'h0, c, 6'h3a, 5'h00, imm, imm ? b[12:0] : 13'h0000};
      instr_word <= lw;
      first_source_reg <= a;
      second_source_reg <= b;
      icc_nzvc <= f;
      higher_trap_pending <= pend;
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      higher_trap_pending <= 1'b0;
      #1;
      check(trap_req === exp && retire === !exp && icc_write_en === 1'b0, "trap decision");
      if (exp) begin
         ntrap++;
         check(instr_ready === 1'b0 && trap_base_reg[11:4] === tt, "trap type or ready");
         check(trap_vector === (svt ? {tba, 12'h000} : {tba, tt, 4'h0}), "trap vector");
         while (trap_req === 1'b1 && n < 20) begin
            @(posedge sys_clk);
            #1;
            n++;
         end
         check(trap_req === 1'b0 && retire === 1'b1 && instr_ready === 1'b1, "trap completion");
      end
   endtask : run_instr

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Watchdog: the whole sequence needs about a thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      conclude();
   end

   initial begin
      {resetn, instr_valid, higher_trap_pending, reg_wr, reg_rd, svt} = 6'h00;
      {instr_word, first_source_reg, second_source_reg, reg_wdata} = '0;
      icc_nzvc = 4'h0;
      reg_addr = 8'h00;
      ack_delay = 2'h0;
      errors = 0;
      total_checks = 0;
      ntrap = 0;
      tba = 20'h12345;
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      #1;
      check(instr_ready === 1'b1 && trap_req === 1'b0 && retire === 1'b0 && irq === 1'b0, "reset outputs");
      reg_check(REG_MASK, 32'h0000_0000);
      reg_check(REG_TBR, 32'h0000_0000);
      reg_check(8'h40, 32'h0000_0000);
      reg_write(REG_TBR, 32'h1234_5fff);
      reg_check(REG_TBR, 32'h1234_5000);
      // Masked nop leaves the interrupt low, the unmasked trap raises it, read clears
      reg_write(REG_MASK, 32'h0000_0001);
      reg_check(REG_STATUS, 32'h0000_0000);
      run_instr(4'h0, 1'b1, 32'h0, 32'h27, 4'hf, 1'b0, 1'b0);
      check(irq === 1'b0, "masked interrupt");
      run_instr(4'h8, 1'b1, 32'h0, 32'h7f, 4'h0, 1'b0, 1'b1);
      check(irq === 1'b1, "interrupt raise");
      reg_check(REG_STATUS, 32'h0000_0009);
      check(irq === 1'b0, "interrupt clear");
      reg_check(REG_LAST, lw);
      // Every condition code against every flag pattern, both operand forms, varied ack waits
      for (int c = 0; c < 16; c++) begin
         for (int f = 0; f < 16; f++) begin
            ack_delay = f[1:0];
            run_instr(c[3:0], f[0] ^ c[0], 32'hffff_ff00 | {24'h0, c[3:0], f[3:0]},
                      (f[0] ^ c[0]) ? {25'h0, f[2:0], c[3:0]} : {25'h0, f[3:0], c[2:0]},
                      f[3:0], 1'b0, want(c[3:0], f[3:0]));
         end
      end
      reg_check(REG_COUNT, ntrap);
      reg_read(REG_STATUS, rd);
      // A higher trap pending turns a true condition into a nop
      run_instr(4'h9, 1'b1, 32'h5, 32'h3, 4'h0, 1'b1, 1'b0);
      run_instr(4'h5, 1'b0, 32'h5, 32'h3, 4'h1, 1'b1, 1'b0);
      reg_check(REG_STATUS, 32'h0000_000a);
      // Deliberately illegal word: only the report bit answers it
      run_instr(4'h0, 1'b1, 32'h0, 32'h80, 4'h0, 1'b0, 1'b0);
      reg_check(REG_STATUS, 32'h0000_000c);
      svt = 1'b1;
      reg_write(REG_CTRL, 32'h0000_0001);
      run_instr(4'h1, 1'b1, 32'h7, 32'h1f, 4'h4, 1'b0, 1'b1);
      conclude();
   end
endmodule : testbench
